// ### logic/disp_cfg.svh
`ifndef DISP_CFG_SVH
`define DISP_CFG_SVH
// Byte and pixel geometry
`define BYTE_BITS       4'd8
`define BIT_CNT_LAST    3'd7
`define PIX_COLS        8'd128
`define PIX_ROWS        8'd160
`define COL_LAST        8'd127
`define ROW_LAST        8'd159
// Window command codes (plain defaults, decoder only tracks addressing)
`define CMD_COL_SET     8'h2a
`define CMD_ROW_SET     8'h2b
`define CMD_MEM_WRITE   8'h2c
`define CMD_SCAN_SET    8'h36
// Scan setting bits: row reverse, column reverse, row/column exchange
`define SCAN_ROW_REV    7
`define SCAN_COL_REV    6
`define SCAN_SWAP       5
// Buffer geometry
`define FIFO_DEPTH      4
`define FIFO_PTR_W      2
`endif

// ### logic/disp_pkg.sv
package disp_pkg;
    // One received byte with its command/data tag
    typedef struct packed {
        logic       is_data;
        logic [7:0] value;
    } rx_byte_s;
    // One pixel write going out to the frame store
    typedef struct packed {
        logic [7:0]  col;
        logic [7:0]  row;
        logic [15:0] rgb;
    } pix_s;
    // Command decode phase
    typedef enum logic [2:0] {
        PH_IDLE, PH_COL, PH_ROW, PH_PIXEL, PH_SCAN
    } phase_e;
endpackage

// ### logic/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "disp_cfg.svh"
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int PW    = `FIFO_PTR_W
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];   // Flip-flop storage
    logic [PW-1:0]    wptr;          // Write index
    logic [PW-1:0]    rptr;          // Read index
    logic [PW:0]      count;         // Fill level
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;
    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rptr];
    // Storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end
    // Pointers and level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            if (push) wptr <= wptr + 1'b1;
            if (pop)  rptr <= rptr + 1'b1;
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### logic/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;   // First stage, read only by the second
    // Two-flop synchroniser for pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// ### logic/display_serial_write_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "disp_cfg.svh"
module display_serial_write_port (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        reset_n_pin,
    input  wire logic        select_n_line,
    input  wire logic        cmd_data_line,
    input  wire logic        serial_clock,
    input  wire logic        serial_data,
    input  wire logic        backlight_ctrl,
    output logic             backlight_on,
    output disp_pkg::pix_s   pix,
    output logic             pix_valid,
    input  wire logic        pix_ready,
    output logic             cmd_strobe,
    output logic [7:0]       cmd_code
);
    import disp_pkg::*;

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic [5:0] pins_s;   // Synchronised pin levels
    // Each pin crosses two flops before use. They clear to zero, so for two
    // cycles after reset the port looks selected and in controller reset;
    // the serial clock reads low then too, so no bit can be taken.
    sync2 #(.W(6)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({reset_n_pin, select_n_line, cmd_data_line,
                serial_clock, serial_data, backlight_ctrl}),
        .q    (pins_s)
    );
    wire ctl_rst_n = pins_s[5];   // Controller reset pin, low resets
    wire sel_n     = pins_s[4];   // Select, active low
    wire cmd_data_level = pins_s[3];   // Low = command, high = data
    wire sclk      = pins_s[2];
    wire sdat      = pins_s[1];
    wire bl_ctrl   = pins_s[0];

    // ****************************************************
    // Serial shift engine
    // ****************************************************
    logic       sclk_d;      // Previous clock level for edge finding
    logic [2:0] bit_cnt;     // Bits taken in current byte
    logic [6:0] shreg;       // First seven bits of the byte
    rx_byte_s   rx;          // Completed byte
    logic       rx_valid;    // Completed byte waiting for the buffer
    // The data pin is only ever sampled; no driver exists for it.
    // Rising edge only counts while selected.
    wire sclk_rise  = sclk && !sclk_d && !sel_n;
    wire last_bit   = (bit_cnt == `BIT_CNT_LAST);
    wire fifo_ready;
    // Each serial clock half must span one full system cycle to be seen
    // Clock history, runs even when deselected so idle low is tracked.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk;
        end
    end
    // Bit counter and shifter; the count wraps from seven to zero itself,
    // so a finished byte needs no separate clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt <= '0;
            shreg   <= '0;
        end else if (sel_n || !ctl_rst_n) begin
            bit_cnt <= '0;
        end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'd1;
            shreg   <= {shreg[5:0], sdat};
        end
    end
    // Byte hand-off; a byte lost only if the buffer stays full for a byte
    // A byte that finds the slot still full overwrites the older one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_valid <= 1'b0;
            rx       <= '0;
        end else if (sclk_rise && last_bit && ctl_rst_n) begin
            rx_valid <= 1'b1;
            rx       <= '{is_data: cmd_data_level, value: {shreg, sdat}};
        end else if (fifo_ready) begin
            rx_valid <= 1'b0;
        end
    end

    // ****************************************************
    // Byte buffer
    // ****************************************************
    // Four bytes of slack let the decoder wait on a stalled pixel sink
    rx_byte_s buf_out;
    logic     buf_valid;
    wire      buf_take;
    byte_fifo #(.WIDTH(9)) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (rx_valid),
        .in_ready  (fifo_ready),
        .in_data   (rx),
        .out_valid (buf_valid),
        .out_ready (buf_take),
        .out_data  (buf_out)
    );

    // ****************************************************
    // Command and window decoder
    // ****************************************************
    phase_e     phase;         // Decode phase
    logic [1:0] arg_idx;       // Parameter byte index
    logic [7:0] col_lo, col_hi, row_lo, row_hi;  // Window bounds
    logic [7:0] col, row;      // Current pixel address
    logic [7:0] scan;          // Orientation setting
    logic       hi_half;       // First colour byte held
    logic [7:0] rgb_hi;        // Held upper colour byte
    logic       win_set;       // Column window programmed since last reset
    // Pixel output waits when its register is full. Back-pressure reaches
    // the buffer, and from there the serial byte slot.
    wire pix_stall  = pix_valid && !pix_ready;
    assign buf_take = buf_valid && !pix_stall && ctl_rst_n;
    wire is_cmd     = buf_take && !buf_out.is_data;
    wire is_dat     = buf_take && buf_out.is_data;
    wire [7:0] bval = buf_out.value;
    wire col_rev    = scan[`SCAN_COL_REV];
    wire row_rev    = scan[`SCAN_ROW_REV];
    wire swap       = scan[`SCAN_SWAP];
    wire pix_done   = is_dat && (phase == PH_PIXEL) && hi_half;

    // Clamp an address to its axis limit.
    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction
    // Step one axis inside its window, wrapping.
    // A window given with its ends swapped never meets its end address;
    // the <= and >= tests then hold the walk at its start, inside the array
    function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic rev);
        if (rev) step = (v <= lo) ? hi : v - 8'd1;
        else     step = (v >= hi) ? lo : v + 8'd1;
    endfunction
    wire col_end = col_rev ? (col <= col_lo) : (col >= col_hi);
    wire row_end = row_rev ? (row <= row_lo) : (row >= row_hi);
    wire [7:0] col_next = step(col, col_lo, col_hi, col_rev);
    wire [7:0] row_next = step(row, row_lo, row_hi, row_rev);
    wire [7:0] col_start = col_rev ? col_hi : col_lo;
    wire [7:0] row_start = row_rev ? row_hi : row_lo;

    // Phase machine
    // A memory write before any column window is dropped, not drawn blind
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase   <= PH_IDLE;
            arg_idx <= '0;
        end else if (!ctl_rst_n) begin
            phase   <= PH_IDLE;
            arg_idx <= '0;
        end else if (is_cmd) begin
            arg_idx <= '0;
            case (bval)
                `CMD_COL_SET:   phase <= PH_COL;
                `CMD_ROW_SET:   phase <= PH_ROW;
                `CMD_MEM_WRITE: phase <= win_set ? PH_PIXEL : PH_IDLE;
                `CMD_SCAN_SET:  phase <= PH_SCAN;
                default:        phase <= PH_IDLE;
            endcase
        end else if (is_dat) begin
            case (phase)
                PH_COL, PH_ROW: begin
                    arg_idx <= arg_idx + 2'd1;
                end
                PH_SCAN: begin
                    phase <= PH_IDLE;
                end
                default: begin
                end
            endcase
        end
    end

    // Window bounds and scan setting; low bytes carry the address
    // Only the column window arms drawing; rows default to the full height
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            col_lo  <= '0;
            col_hi  <= `COL_LAST;
            row_lo  <= '0;
            row_hi  <= `ROW_LAST;
            scan    <= '0;
            win_set <= 1'b0;
        end else if (!ctl_rst_n) begin
            col_lo  <= '0;
            col_hi  <= `COL_LAST;
            row_lo  <= '0;
            row_hi  <= `ROW_LAST;
            scan    <= '0;
            win_set <= 1'b0;
        end else if (is_dat) begin
            case (phase)
                PH_COL: begin
                    if (arg_idx == 2'd1) col_lo <= clamp(bval, `COL_LAST);
                    if (arg_idx == 2'd3) col_hi <= clamp(bval, `COL_LAST);
                    if (arg_idx == 2'd3) win_set <= 1'b1;
                end
                PH_ROW: begin
                    if (arg_idx == 2'd1) row_lo <= clamp(bval, `ROW_LAST);
                    if (arg_idx == 2'd3) row_hi <= clamp(bval, `ROW_LAST);
                end
                PH_SCAN: begin
                    scan <= bval;
                end
                default: begin
                end
            endcase
        end
    end

    // Pixel address walk and colour assembly.
    // The address steps with the low colour byte, on the edge that registers the pixel
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            col     <= '0;
            row     <= '0;
            hi_half <= 1'b0;
            rgb_hi  <= '0;
        end else if (!ctl_rst_n || (is_cmd && bval == `CMD_MEM_WRITE)) begin
            col     <= col_start;
            row     <= row_start;
            hi_half <= 1'b0;
        end else if (is_dat && phase == PH_PIXEL) begin
            hi_half <= !hi_half;
            if (!hi_half) begin
                rgb_hi <= bval;
            end else if (swap) begin
                row <= row_next;
                if (row_end) col <= col_next;
            end else begin
                col <= col_next;
                if (col_end) row <= row_next;
            end
        end
    end

    // Pixel output register
    // Held until the sink takes it; a stall backs up the byte buffer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pix_valid <= 1'b0;
            pix       <= '0;
        end else if (pix_done) begin
            pix_valid <= 1'b1;
            pix       <= '{col: col, row: row, rgb: {rgb_hi, bval}};
        end else if (pix_ready) begin
            pix_valid <= 1'b0;
        end
    end

    // Command report and backlight
    // The strobe lasts one cycle; the code holds until the next command
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_strobe   <= 1'b0;
            cmd_code     <= '0;
            backlight_on <= 1'b0;
        end else begin
            cmd_strobe   <= is_cmd;
            if (is_cmd) cmd_code <= bval;
            backlight_on <= bl_ctrl;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    // All checks run on the system clock behind the main reset
    sequence s_sel_rise;
        !sel_n ##0 sclk && !sclk_d;
    endsequence
    AST_DESELECT_IDLE: assert property (@(posedge clk) disable iff (!rstn)
        sel_n |=> bit_cnt == 3'd0) else $error("count moved while deselected");
    AST_BIT_STEP: assert property (@(posedge clk) disable iff (!rstn)
        s_sel_rise ##0 ctl_rst_n |=> bit_cnt == $past(bit_cnt) + 3'd1)
        else $error("bit not counted");
    AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise && !sel_n && ctl_rst_n && !last_bit |=> shreg[0] == $past(sdat))
        else $error("shift order wrong");
    AST_BYTE_DONE: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise && last_bit && ctl_rst_n |=> rx_valid && rx.value[0] == $past(sdat))
        else $error("byte not completed on eighth bit");
    AST_TAG: assert property (@(posedge clk) disable iff (!rstn)
        sclk_rise && last_bit && ctl_rst_n |=> rx.is_data == $past(cmd_data_level))
        else $error("tag not taken with eighth bit");
    AST_DESELECT_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        $rose(sel_n) |=> bit_cnt == 3'd0) else $error("partial byte kept");
    AST_BOUNDS: assert property (@(posedge clk) disable iff (!rstn)
        pix_valid |-> pix.col <= `COL_LAST && pix.row <= `ROW_LAST)
        else $error("pixel address out of range");
    AST_BACKLIGHT: assert property (@(posedge clk) disable iff (!rstn)
        backlight_on == $past(bl_ctrl)) else $error("backlight lag");
    AST_RESET_PIN: assert property (@(posedge clk) disable iff (!rstn)
        !ctl_rst_n |=> phase == PH_IDLE && !win_set) else $error("pin reset ignored");
    AST_WINDOW_FIRST: assert property (@(posedge clk) disable iff (!rstn)
        phase == PH_PIXEL |-> win_set) else $error("pixels before window");
    AST_PIXEL_STEP: assert property (@(posedge clk) disable iff (!rstn)
        pix_done && !swap && !col_end |=> col == $past(col_next))
        else $error("column did not step");
    sequence s_pix_stall;
        pix_valid && !pix_ready;
    endsequence
    AST_PIX_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        s_pix_stall |=> pix_valid && $stable(pix)) else $error("stalled pixel changed");
    AST_ROW_STEP: assert property (@(posedge clk) disable iff (!rstn)
        pix_done && swap && !row_end |=> row == $past(row_next))
        else $error("row did not step");
    AST_CMD_REPORT: assert property (@(posedge clk) disable iff (!rstn)
        is_cmd |=> cmd_strobe && cmd_code == $past(bval))
        else $error("command not reported");
    AST_DATA_QUIET: assert property (@(posedge clk) disable iff (!rstn)
        is_dat |=> !cmd_strobe) else $error("data byte strobed");
    AST_SCAN_STORE: assert property (@(posedge clk) disable iff (!rstn)
        is_dat && phase == PH_SCAN |=> scan == $past(bval)) else $error("scan not kept");
endmodule
`default_nettype wire

// ### test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************************
// Serial host that writes the display port in mode 0
// ********************************************************
module host_model (
    input  wire logic clk,
    output logic      select_n_line,
    output logic      cmd_data_line,
    output logic      serial_clock,
    output logic      serial_data
);
    // Idle: deselected, clock low
    initial begin
        select_n_line = 1'b1;
        cmd_data_line = 1'b0;
        serial_clock  = 1'b0;
        serial_data   = 1'b0;
    end

    // Half of the 80 ns link period, moved on falling system edges
    task automatic half();
        repeat (4) @(negedge clk);
    endtask

    // Leading n bits of a byte; data set up a half period before the rise
    task automatic send_bits(input logic dc, input logic [7:0] b, input int n);
        select_n_line = 1'b0;
        cmd_data_line = dc;
        for (int i = 7; i > 7 - n; i--) begin
            serial_data  = b[i];
            half();
            serial_clock = 1'b1;
            half();
            serial_clock = 1'b0;
        end
    endtask

    // Whole units only
    task automatic send_byte(input logic dc, input logic [7:0] b);
        send_bits(dc, b, 8);
    endtask

    // Released data line shows the inverse so no stale bit reads back
    task automatic deselect();
        select_n_line = 1'b1;
        serial_data   = ~serial_data;
        half();
    endtask

    // Clock and data wiggle while deselected; the port must ignore it
    task automatic noise();
        select_n_line = 1'b1;
        for (int i = 0; i < 8; i++) begin
            serial_data  = i[0];
            half();
            serial_clock = 1'b1;
            half();
            serial_clock = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "disp_cfg.svh"
module testbench;
    import disp_pkg::*;
    // ********************************************************
    // Signals
    // ********************************************************
    logic       clk, rstn, reset_n_pin, backlight_ctrl, backlight_on;
    logic       select_n_line, cmd_data_line, serial_clock, serial_data;
    logic       pix_valid, pix_ready, cmd_strobe;
    logic [7:0] cmd_code;
    pix_s       pix;
    int         error_cnt, comparisons;
    int         c0, c1, r0, r1;   // Expected window
    pix_s       pixq[$];          // Accepted pixels
    logic [7:0] cmdq[$];          // Strobed commands

    always #5 clk = ~clk;

    host_model host (.clk(clk), .select_n_line(select_n_line), .cmd_data_line(cmd_data_line),
        .serial_clock(serial_clock), .serial_data(serial_data));
    display_serial_write_port i_dut (.clk(clk), .rstn(rstn), .reset_n_pin(reset_n_pin),
        .select_n_line(select_n_line), .cmd_data_line(cmd_data_line),
        .serial_clock(serial_clock), .serial_data(serial_data),
        .backlight_ctrl(backlight_ctrl), .backlight_on(backlight_on), .pix(pix),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code));

    // Record every strobe and every accepted pixel; a long strobe shows as a duplicate
    always @(posedge clk) begin
        if (cmd_strobe === 1'b1) cmdq.push_back(cmd_code);
        if (pix_valid === 1'b1 && pix_ready === 1'b1) pixq.push_back(pix);
    end

    // ********************************************************
    // Helpers
    // ********************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Bounded wait for n queue entries; a hang ends the run
    task automatic wait_q(input int n, input logic is_pix);
        int k;
        for (k = 0; k < 300 && (is_pix ? pixq.size() : cmdq.size()) < n; k++) @(negedge clk);
        if ((is_pix ? pixq.size() : cmdq.size()) < n) begin
            error_cnt++;
            $display("mismatch queue fill expected %0d seen fewer", n);
            finish_test();
        end
    endtask

    // Bounded wait for a pixel to be offered; a hang ends the run
    task automatic wait_valid();
        int k;
        for (k = 0; k < 100 && pix_valid !== 1'b1; k++) @(negedge clk);
        if (pix_valid !== 1'b1) begin
            error_cnt++;
            $display("mismatch pixel valid expected 1 seen 0");
            finish_test();
        end
    endtask

    // Address of the idx-th pixel under a scan setting, wrapping in the window
    function automatic logic [15:0] exp_addr(input logic [7:0] scan, input int idx);
        int w, h, n, ci, ri;
        w  = c1 - c0 + 1;
        h  = r1 - r0 + 1;
        n  = idx % (w * h);
        ci = scan[`SCAN_SWAP] ? n / h : n % w;
        ri = scan[`SCAN_SWAP] ? n % h : n / w;
        ci = scan[`SCAN_COL_REV] ? c1 - ci : c0 + ci;
        ri = scan[`SCAN_ROW_REV] ? r1 - ri : r0 + ri;
        return {ci[7:0], ri[7:0]};
    endfunction

    // Column and row windows, high byte then low byte; far ends clamp
    task automatic window(input int a, input int b, input int c, input int d);
        logic [7:0] seq [10];
        seq = '{`CMD_COL_SET, 8'h00, a[7:0], 8'h00, b[7:0],
                `CMD_ROW_SET, 8'h00, c[7:0], 8'h00, d[7:0]};
        for (int i = 0; i < 10; i++) host.send_byte(i % 5 != 0, seq[i]);
        c0 = a;
        c1 = (b > 127) ? 127 : b;
        r0 = c;
        r1 = (d > 159) ? 159 : d;
    endtask

    // Scan setting, memory write, n pixels, then compare every address
    task automatic draw(input logic [7:0] scan, input int n);
        logic [15:0] rgb;
        pixq.delete();
        host.send_byte(1'b0, `CMD_SCAN_SET);
        host.send_byte(1'b1, scan);
        host.send_byte(1'b0, `CMD_MEM_WRITE);
        for (int i = 0; i < n; i++) begin
            rgb = 16'hc300 + i[15:0];
            host.send_byte(1'b1, rgb[15:8]);
            host.send_byte(1'b1, rgb[7:0]);
        end
        host.deselect();
        wait_q(n, 1'b1);
        for (int i = 0; i < n; i++) begin
            check("pixel", pixq[i], {exp_addr(scan, i), 16'hc300 + i[15:0]});
        end
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_backlight();
        for (int v = 1; v >= 0; v--) begin
            backlight_ctrl = v[0];
            repeat (2) @(negedge clk);
            check("backlight early", backlight_on, !v[0]);
            @(negedge clk);
            check("backlight", backlight_on, v[0]);
        end
        $display("test backlight done");
    endtask

    // Asymmetric codes catch bit order; a data byte must not strobe
    task automatic t_commands();
        cmdq.delete();
        host.send_byte(1'b0, 8'h80);
        host.send_byte(1'b1, 8'h5a);
        host.send_byte(1'b0, 8'h01);
        host.send_byte(1'b0, 8'h11);
        host.deselect();
        wait_q(3, 1'b0);
        check("command count", cmdq.size(), 3);
        check("command first", cmdq[0], 8'h80);
        check("command second", cmdq[1], 8'h01);
        check("command third", cmdq[2], 8'h11);
        $display("test commands done");
    endtask

    // Deselected clocking and a cut-off byte leave no trace
    task automatic t_select();
        cmdq.delete();
        host.noise();
        host.send_bits(1'b0, 8'hff, 3);
        host.deselect();
        host.send_byte(1'b0, 8'h3c);
        host.deselect();
        wait_q(1, 1'b0);
        repeat (20) @(negedge clk);
        check("select count", cmdq.size(), 1);
        check("select byte", cmdq[0], 8'h3c);
        $display("test select done");
    endtask

    // Each single scan bit, and no bit, over a 2 by 2 window, wrapping once
    task automatic t_pixels();
        logic [7:0] scans [4];
        scans = '{8'h80, 8'h40, 8'h20, 8'h00};
        window(2, 3, 5, 6);
        for (int s = 0; s < 4; s++) draw(scans[s], 5);
        $display("test pixels done");
    endtask

    // Sink stalls: the pixel holds until accepted
    task automatic t_stall();
        pixq.delete();
        pix_ready = 1'b0;
        host.send_byte(1'b0, `CMD_MEM_WRITE);
        host.send_byte(1'b1, 8'h5a);
        host.send_byte(1'b1, 8'ha5);
        host.deselect();
        wait_valid();
        repeat (10) @(negedge clk);
        check("stalled valid", pix_valid, 1);
        check("stalled pixel", pix, {exp_addr(8'h00, 0), 16'h5aa5});
        pix_ready = 1'b1;
        wait_q(1, 1'b1);
        check("released pixel", pixq[0], {exp_addr(8'h00, 0), 16'h5aa5});
        $display("test stall done");
    endtask

    // Far ends beyond the array are clamped to the last column and row
    task automatic t_clamp();
        window(126, 200, 159, 255);
        draw(8'h00, 3);
        $display("test clamp done");
    endtask

    // Bytes during controller reset are dropped
    task automatic t_reset_pin();
        cmdq.delete();
        reset_n_pin = 1'b0;
        repeat (5) @(negedge clk);
        host.send_byte(1'b0, 8'h11);
        host.deselect();
        repeat (20) @(negedge clk);
        check("dropped in reset", cmdq.size(), 0);
        reset_n_pin = 1'b1;
        repeat (5) @(negedge clk);
        host.send_byte(1'b0, 8'h12);
        host.deselect();
        wait_q(1, 1'b0);
        check("after reset", cmdq[0], 8'h12);
        $display("test reset pin done");
    endtask

    // A stalled sink backs bytes up: the buffer keeps four, the serial slot
    // one more, and a sixth byte overwrites the slot
    task automatic t_fifo();
        pixq.delete();
        window(0, 1, 0, 1);
        pix_ready = 1'b0;
        host.send_byte(1'b0, `CMD_MEM_WRITE);
        host.send_byte(1'b1, 8'h12);
        host.send_byte(1'b1, 8'h34);
        wait_valid();
        cmdq.delete();
        for (int k = 0; k < 6; k++) host.send_byte(1'b0, 8'h81 + k[7:0]);
        host.deselect();
        repeat (20) @(negedge clk);
        check("buffer held", cmdq.size(), 0);
        pix_ready = 1'b1;
        wait_q(`FIFO_DEPTH + 1, 1'b0);
        check("buffer pixel", pixq[0], {exp_addr(8'h00, 0), 16'h1234});
        for (int k = 0; k < `FIFO_DEPTH; k++) begin
            check("buffer word", cmdq[k], 8'h81 + k);
        end
        check("buffer last", cmdq[`FIFO_DEPTH], 8'h86);
        repeat (20) @(negedge clk);
        check("buffer count", cmdq.size(), `FIFO_DEPTH + 1);
        $display("test buffer done");
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        reset_n_pin = 1'b1;
        backlight_ctrl = 1'b0;
        pix_ready = 1'b1;
        error_cnt = 0;
        comparisons = 0;
        repeat (10) @(negedge clk);
        check("valid in reset", pix_valid, 0);
        check("strobe in reset", cmd_strobe, 0);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        t_backlight();
        t_commands();
        t_select();
        t_pixels();
        t_stall();
        t_clamp();
        t_reset_pin();
        t_fifo();
        finish_test();
    end
endmodule
`default_nettype wire
